/* File: logic/sia_pkg.sv */
// Shared constants, carrier structs and state type for the stream adapter chain.
// Assumes one clock, an active-low asynchronous reset, and on-chip stream partners.
package sia_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int IN_DATA_W = 128;
  localparam int OUT_DATA_W = 32;
  localparam int WORD_IDX_W = 2;
  localparam logic [WORD_IDX_W-1:0] FIRST_WORD_IDX = 2'h0;
  localparam logic [WORD_IDX_W-1:0] LAST_WORD_IDX = 2'h3;
  localparam int IN_CHAN_W = 6;
  localparam int MID_CHAN_W = 8;
  localparam int OUT_CHAN_W = 4;
  localparam logic [MID_CHAN_W-IN_CHAN_W-1:0] CHAN_PAD = 2'h0;
  localparam logic [MID_CHAN_W-OUT_CHAN_W-1:0] CHAN_HIGH_NONE = 4'h0;
  localparam int ERR_W = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_LVL_W = 4;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_TWO = 16'h0002;

  // ****************************************************************
  // Error bit positions on each side
  // ****************************************************************
  localparam int SRC_ERR_LEN = 0;
  localparam int SRC_ERR_CRC = 1;
  localparam int SRC_ERR_OVF = 2;
  localparam int SNK_ERR_LEN = 0;
  localparam int SNK_ERR_CRC = 1;
  localparam int SNK_ERR_PAR = 2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic sop;
    logic eop;
    logic [ERR_W-1:0] err;
    logic [IN_CHAN_W-1:0] chan;
    logic [IN_DATA_W-1:0] data;
  } sia_in_beat_type;

  typedef struct packed {
    logic sop;
    logic eop;
    logic [ERR_W-1:0] err;
    logic [MID_CHAN_W-1:0] chan;
    logic [IN_DATA_W-1:0] data;
  } sia_mid_beat_type;

  typedef struct packed {
    logic sop;
    logic eop;
    logic [ERR_W-1:0] err;
    logic [OUT_CHAN_W-1:0] chan;
    logic [OUT_DATA_W-1:0] data;
  } sia_out_word_type;

  typedef enum logic {SPLIT_EMPTY, SPLIT_SEND} sia_split_state_type;

endpackage

/* File: logic/sia_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; read data is shown combinationally from the head slot.
`timescale 1ns/100ps

module sia_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int LVL_W = $clog2(DEPTH+1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH-1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);
  localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
  logic [LVL_W-1:0] cnt_reg, cnt_next;
  logic push;
  logic pop;

  // Ready and valid come from the count alone, so full and empty are exact
  assign wr_ready = (cnt_reg != LVL_FULL);
  assign rd_valid = (cnt_reg != '0);
  assign rd_data = mem_reg[rd_ptr_reg];
  assign level = cnt_reg;

  // Next pointers, count and storage
  always_comb begin
    push = wr_valid && wr_ready;
    pop = rd_valid && rd_ready;
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = wr_data;
      wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + LVL_ONE;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - LVL_ONE;
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg <= '{default: '0};
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

/* File: logic/sia_adapter_top.sv */
// Stream adapter chain: ready-less 128-bit source in, ready-capable 32-bit sink out.
// Channel widen then narrow, error remap, FIFO timing buffer, width split.
// Assumes one point-to-point partner on each side, synchronous to clk.
`timescale 1ns/100ps

module sia_adapter_top
  import sia_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input sia_in_beat_type in_beat,
  output logic out_valid,
  input wire logic out_ready,
  output sia_out_word_type out_word,
  output logic err_unsupported,
  output logic drop_overflow,
  output logic drop_channel,
  output logic [FIFO_LVL_W-1:0] fifo_level,
  output logic [CNT_W-1:0] words_sent,
  output logic [CNT_W-1:0] beats_dropped
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Zero-extend the source channel into the wider middle field
  function automatic logic [MID_CHAN_W-1:0] widen_chan(input logic [IN_CHAN_W-1:0] c);
    widen_chan = {CHAN_PAD, c};
  endfunction

  // Sink can only represent channels whose upper bits are all clear
  function automatic logic chan_fits(input logic [MID_CHAN_W-1:0] c);
    chan_fits = (c[MID_CHAN_W-1:OUT_CHAN_W] == CHAN_HIGH_NONE);
  endfunction

  // Translate source error bits onto the sink layout
  function automatic logic [ERR_W-1:0] map_err(input logic [ERR_W-1:0] e);
    logic [ERR_W-1:0] m;
    m = '0;
    m[SNK_ERR_LEN] = e[SRC_ERR_LEN];
    m[SNK_ERR_CRC] = e[SRC_ERR_CRC];
    m[SNK_ERR_PAR] = 1'b0;
    map_err = m;
  endfunction

  // Cut one output word from a stored beat; lowest word goes first
  function automatic sia_out_word_type make_word(input sia_mid_beat_type b,
                                                 input logic [WORD_IDX_W-1:0] idx);
    sia_out_word_type w;
    w.data = b.data[OUT_DATA_W*int'(idx) +: OUT_DATA_W];
    w.sop = b.sop && (idx == FIRST_WORD_IDX);
    w.eop = b.eop && (idx == LAST_WORD_IDX);
    w.err = b.err;
    w.chan = b.chan[OUT_CHAN_W-1:0];
    make_word = w;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sia_mid_beat_type wr_beat;
  sia_mid_beat_type rd_beat;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [FIFO_LVL_W-1:0] fifo_lvl;

  logic err_unsup_reg, err_unsup_next;
  logic drop_ovf_reg, drop_ovf_next;

  sia_split_state_type state_reg, state_next;
  sia_mid_beat_type beat_reg, beat_next;
  logic [WORD_IDX_W-1:0] idx_reg, idx_next;
  logic out_valid_reg, out_valid_next;
  sia_out_word_type out_word_reg, out_word_next;
  logic drop_chan_reg, drop_chan_next;

  logic [CNT_W-1:0] sent_cnt_reg, sent_cnt_next;
  logic [CNT_W-1:0] drop_cnt_reg, drop_cnt_next;
  logic [FIFO_LVL_W-1:0] level_reg, level_next;

  // ****************************************************************
  // Input side
  // ****************************************************************

  // The input port is a sink: its fields feed the FIFO with no register in between
  always_comb begin
    wr_beat.sop = in_beat.sop;
    wr_beat.eop = in_beat.eop;
    wr_beat.err = map_err(in_beat.err);
    wr_beat.chan = widen_chan(in_beat.chan);
    wr_beat.data = in_beat.data;
  end

  // The source has no ready, so a beat offered while the FIFO is full is lost
  // and reported; it cannot be held back
  always_comb begin
    drop_ovf_next = in_valid && !fifo_wr_ready;
    err_unsup_next = in_valid && in_beat.err[SRC_ERR_OVF];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_ovf_reg <= 1'b0;
      err_unsup_reg <= 1'b0;
    end else begin
      drop_ovf_reg <= drop_ovf_next;
      err_unsup_reg <= err_unsup_next;
    end
  end

  // ****************************************************************
  // Timing buffer
  // ****************************************************************

  // Eight beats of slack absorb the sink's stalls against a source that cannot wait
  sia_fifo #(
    .WIDTH($bits(sia_mid_beat_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr_valid(in_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(wr_beat),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(rd_beat),
    .level(fifo_lvl)
  );

  // ****************************************************************
  // Width split and channel filter
  // ****************************************************************

  // One beat is held while its four words go out; a new beat is fetched only
  // when the holder is empty, which costs one idle cycle per beat but keeps
  // the FIFO read path free of the output handshake
  always_comb begin
    state_next = state_reg;
    beat_next = beat_reg;
    idx_next = idx_reg;
    out_valid_next = out_valid_reg;
    out_word_next = out_word_reg;
    drop_chan_next = 1'b0;
    fifo_rd_ready = 1'b0;
    if (out_valid_reg && out_ready) begin
      out_valid_next = 1'b0;
    end
    case (state_reg)
      SPLIT_EMPTY: begin
        fifo_rd_ready = 1'b1;
        if (fifo_rd_valid) begin
          if (chan_fits(rd_beat.chan)) begin
            beat_next = rd_beat;
            idx_next = FIRST_WORD_IDX;
            state_next = SPLIT_SEND;
          end else begin
            drop_chan_next = 1'b1;
          end
        end
      end
      SPLIT_SEND: begin
        // A word is loaded only when the previous one is gone or leaving now
        if (!out_valid_reg || out_ready) begin
          out_valid_next = 1'b1;
          out_word_next = make_word(beat_reg, idx_reg);
          idx_next = idx_reg + 1'b1;
          if (idx_reg == LAST_WORD_IDX) begin
            state_next = SPLIT_EMPTY;
          end
        end
      end
      default: begin
        state_next = SPLIT_EMPTY;
      end
    endcase
  end

  // Output word and valid leave straight from these flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SPLIT_EMPTY;
      beat_reg <= '0;
      idx_reg <= FIRST_WORD_IDX;
      out_valid_reg <= 1'b0;
      out_word_reg <= '0;
      drop_chan_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      beat_reg <= beat_next;
      idx_reg <= idx_next;
      out_valid_reg <= out_valid_next;
      out_word_reg <= out_word_next;
      drop_chan_reg <= drop_chan_next;
    end
  end

  // ****************************************************************
  // Statistics
  // ****************************************************************

  // Counters wrap; software-free status, so no clear is provided
  always_comb begin
    sent_cnt_next = sent_cnt_reg;
    drop_cnt_next = drop_cnt_reg;
    level_next = fifo_lvl;
    if (out_valid_reg && out_ready) begin
      sent_cnt_next = sent_cnt_reg + CNT_ONE;
    end
    if (drop_ovf_next && drop_chan_next) begin
      drop_cnt_next = drop_cnt_reg + CNT_TWO;
    end else if (drop_ovf_next || drop_chan_next) begin
      drop_cnt_next = drop_cnt_reg + CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sent_cnt_reg <= '0;
      drop_cnt_reg <= '0;
      level_reg <= '0;
    end else begin
      sent_cnt_reg <= sent_cnt_next;
      drop_cnt_reg <= drop_cnt_next;
      level_reg <= level_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign out_valid = out_valid_reg;
  assign out_word = out_word_reg;
  assign err_unsupported = err_unsup_reg;
  assign drop_overflow = drop_ovf_reg;
  assign drop_channel = drop_chan_reg;
  assign fifo_level = level_reg;
  assign words_sent = sent_cnt_reg;
  assign beats_dropped = drop_cnt_reg;

endmodule

/* File: testbench/sia_adapter_props.sv */
// Checker for the adapter chain top, bound in below.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps

module sia_adapter_props
  import sia_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire sia_in_beat_type in_beat,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire sia_out_word_type out_word,
  input wire logic err_unsupported,
  input wire logic drop_overflow,
  input wire logic drop_channel,
  input wire logic [FIFO_LVL_W-1:0] fifo_level,
  input wire logic [CNT_W-1:0] words_sent,
  input wire logic [CNT_W-1:0] beats_dropped
);
  // ****************************************
  // Word index helper
  // ****************************************
  logic [1:0] widx_reg;
  logic [1:0] widx_next;

  // Dropped beats emit no words, so a count of taken words stays aligned
  always_comb begin
    widx_next = widx_reg;
    if (out_valid && out_ready) begin
      widx_next = widx_reg + 2'h1;
    end
  end

  // Index register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      widx_reg <= 2'h0;
    end else begin
      widx_reg <= widx_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Stalled output must not move
  hold_stall_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("output word moved while stalled");
  unsup_flag_a: assert property (in_valid && in_beat.err[SRC_ERR_OVF] |=> err_unsupported)
    else $error("unsupported error not flagged");
  unsup_quiet_a: assert property (!(in_valid && in_beat.err[SRC_ERR_OVF]) |=> !err_unsupported)
    else $error("unsupported flag without cause");
  parity_zero_a: assert property (out_valid |-> !out_word.err[SNK_ERR_PAR])
    else $error("sink-only error bit not zero");
  word_gap_a: assert property (out_valid && out_ready && widx_reg != 2'h3 |=> out_valid)
    else $error("gap inside a split beat");
  sop_first_a: assert property (out_valid && out_word.sop |-> widx_reg == 2'h0)
    else $error("start marker off first word");
  eop_last_a: assert property (out_valid && out_word.eop |-> widx_reg == 2'h3)
    else $error("end marker off last word");
  sent_count_a: assert property (out_valid && out_ready |=> words_sent == $past(words_sent) + CNT_ONE)
    else $error("word count did not step");
  sent_still_a: assert property (!(out_valid && out_ready) |=> $stable(words_sent))
    else $error("word count moved without transfer");
  // Level lags the internal count by one cycle, exactly as the drop flag does
  ovf_exact_a: assert property (drop_overflow ==
    ($past(in_valid) && fifo_level == FIFO_LVL_W'(FIFO_DEPTH)))
    else $error("overflow drop flag wrong");
  drop_step_a: assert property ((drop_overflow ^ drop_channel) |->
    beats_dropped == $past(beats_dropped) + CNT_ONE)
    else $error("drop count did not step");
  drop_still_a: assert property (!drop_overflow && !drop_channel |->
    $stable(beats_dropped))
    else $error("drop count moved without drop");
  level_max_a: assert property (fifo_level <= FIFO_LVL_W'(FIFO_DEPTH))
    else $error("buffer level above depth");
endmodule

bind sia_adapter_top sia_adapter_props u_sia_adapter_props (
  .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_beat(in_beat),
  .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
  .err_unsupported(err_unsupported), .drop_overflow(drop_overflow),
  .drop_channel(drop_channel), .fifo_level(fifo_level),
  .words_sent(words_sent), .beats_dropped(beats_dropped));

/* File: testbench/sia_sink_model.sv */
// Sink partner for the chain output: random back pressure, counts words.
// Assumes one clock; ready moves only on the falling edge.
`timescale 1ns/100ps

module sia_sink_model
  import sia_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic out_valid,
  input wire sia_out_word_type out_word,
  input wire logic [7:0] ready_pct,
  output logic out_ready,
  output logic [CNT_W-1:0] taken
);
  initial out_ready = 1'b0;

  // Ready low in reset; a real sink may stall at any time
  always @(negedge clk) begin
    out_ready <= rst_n && (($urandom % 100) < ready_pct);
  end

  // A word counts only on a rising edge with valid and ready
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken <= '0;
    end else if (out_valid && out_ready) begin
      taken <= taken + CNT_ONE;
    end
  end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the adapter chain, with a queue-based model.
// Assumes the sink model file and the bound checker are compiled first.
`timescale 1ns/100ps

module tb
  import sia_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid = 1'b0;
  sia_in_beat_type in_beat = '0;
  logic out_valid;
  logic out_ready;
  sia_out_word_type out_word;
  logic [FIFO_LVL_W-1:0] fifo_level;
  logic [CNT_W-1:0] words_sent;
  logic [CNT_W-1:0] beats_dropped;
  logic [CNT_W-1:0] taken;
  logic err_unsupported;
  logic drop_overflow;
  logic drop_channel;
  logic [7:0] ready_pct = 8'h64;
  int err_total = 0;
  int checks = 0;
  int n_words = 0;
  int n_drop = 0;
  int n_ovf = 0;
  int n_unsup = 0;
  int ovf_seen = 0;
  int chan_seen = 0;
  int unsup_seen = 0;
  sia_out_word_type exp_q[$];

  always #2 clk = ~clk;

  sia_adapter_top u_sia_adapter_top (.clk(clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_beat(in_beat), .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
    .err_unsupported(err_unsupported), .drop_overflow(drop_overflow),
    .drop_channel(drop_channel), .fifo_level(fifo_level),
    .words_sent(words_sent), .beats_dropped(beats_dropped));
  sia_sink_model u_sia_sink_model (.clk(clk), .rst_n(rst_n), .out_valid(out_valid),
    .out_word(out_word), .ready_pct(ready_pct), .out_ready(out_ready), .taken(taken));

  // ****************************************
  // Compare, stimulus and closing tasks
  // ****************************************
  task automatic cmp_word(input sia_out_word_type g, input sia_out_word_type e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_cnt(input logic [CNT_W-1:0] g, input logic [CNT_W-1:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Valid stays up between calls so back-to-back beats need no extra edge
  task automatic send(input logic [IN_CHAN_W-1:0] ch, input logic [ERR_W-1:0] er,
                      input logic keep);
    sia_in_beat_type b;
    sia_out_word_type w;
    b.data = {$urandom, $urandom, $urandom, $urandom};
    b.sop = 1'($urandom);
    b.eop = 1'($urandom);
    b.err = er;
    b.chan = ch;
    if (er[SRC_ERR_OVF]) begin
      n_unsup++;
    end
    if (keep && ch < 6'h10) begin
      for (int k = 0; k < 4; k++) begin
        w.sop = b.sop && (k == 0);
        w.eop = b.eop && (k == 3);
        w.err = {1'b0, b.err[SRC_ERR_CRC], b.err[SRC_ERR_LEN]};
        w.chan = b.chan[OUT_CHAN_W-1:0];
        w.data = b.data[k*OUT_DATA_W +: OUT_DATA_W];
        exp_q.push_back(w);
      end
      n_words += 4;
    end else begin
      n_drop++;
      if (!keep) begin
        n_ovf++;
      end
    end
    @(negedge clk);
    in_valid = 1'b1;
    in_beat = b;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      in_valid = 1'b0;
    end
  endtask

  // Bounded wait for the model queue to empty
  task automatic drain();
    for (int t = 0; t < 3000 && exp_q.size() != 0; t++) begin
      @(negedge clk);
    end
    cmp_cnt(16'(exp_q.size()), 16'h0000);
    idle(8);
  endtask

  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Every accepted word is matched against the model, in order
  always @(posedge clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
      cmp_word(out_word, exp_q.size() != 0 ? exp_q.pop_front() : '1);
    end
  end

  // Pulse outputs stand one cycle each, so every high sample is one event
  always @(posedge clk) begin
    if (rst_n && drop_overflow === 1'b1) begin
      ovf_seen++;
    end
    if (rst_n && drop_channel === 1'b1) begin
      chan_seen++;
    end
    if (rst_n && err_unsupported === 1'b1) begin
      unsup_seen++;
    end
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    #60000;
    err_total++;
    close_out();
  end

  initial begin
    void'($urandom(11481));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // Paced traffic, channel boundary, every error code, random stalls
    ready_pct = 8'h4B;
    send(6'h0F, 3'h0, 1'b1);
    send(6'h10, 3'h0, 1'b1);
    idle(10);
    for (int i = 0; i < 40; i++) begin
      send(6'($urandom), 3'(i), 1'b1);
      idle(9);
    end
    drain();
    // Back-to-back burst absorbed by the buffer at full sink rate
    ready_pct = 8'h64;
    for (int i = 0; i < 8; i++) begin
      send(6'(i), 3'($urandom), 1'b1);
    end
    idle(1);
    drain();
    cmp_cnt(beats_dropped, 16'(n_drop));
    // Stalled sink: one beat held by the splitter plus eight buffered
    ready_pct = 8'h00;
    idle(4);
    for (int i = 0; i < 20; i++) begin
      send(6'($urandom % 16), 3'($urandom), i < 9);
    end
    idle(4);
    ready_pct = 8'h64;
    drain();
    cmp_cnt(beats_dropped, 16'(n_drop));
    cmp_cnt(words_sent, 16'(n_words));
    cmp_cnt(taken, 16'(n_words));
    cmp_cnt(16'(fifo_level), 16'h0000);
    cmp_cnt(16'(ovf_seen), 16'(n_ovf));
    cmp_cnt(16'(chan_seen), 16'(n_drop - n_ovf));
    cmp_cnt(16'(unsup_seen), 16'(n_unsup));
    close_out();
  end
endmodule
